// File: design/nco_pkg.sv
// Constants and types for the oscillator with phase modulation
// Summary of operation
// - A 28-bit phase accumulator advances once per master clock cycle while the sample FIFO has room.
// - One full phase cycle is 2^28 counts; the accumulator wraps modulo that.
// - Increment comes from frequency word a or b, by pin or control bit.
// - Changing frequency word only changes increment; accumulator never cleared.
// - A phase offset from 12-bit phase registers follows the accumulator.
// - The phase offset is added to the accumulator's most significant bits.
// - Two phase offset registers; one offset step is 1/4096 of a cycle.
// - Phase to the sine lookup is the upper 12 bits; lower bits dropped.
// - The sine lookup uses the truncated phase as address, returns amplitude.
// - Amplitude drives a 10-bit converter; lookup phase has two more bits.
// - Sign output enable and waveform mode bits decide sine lookup use.
// - Comparator path is enabled only when source select and enable are 1.
// - Offset comes from phase register a or b, by pin or control bit.
// - Datapath reset clears internal state to midscale; keeps all registers.
// - With sign pin enabled, source select picks comparator or oscillator MSB.
package nco_pkg;
	localparam int ACC_W = 28;
	localparam int PH_W = 12;
	localparam int DAC_W = 10;
	localparam int FIFO_DEPTH = 32;
	localparam int ADDR_W = 5;

	localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_FREQ_A = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_FREQ_B = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_PHASE_A = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_PHASE_B = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;

	localparam int CTRL_FREQ_WORD_SELECT_BIT_BIT = 0;
	localparam int CTRL_PSEL_BIT = 1;
	localparam int CTRL_PIN_MODE_BIT = 2;
	localparam int CTRL_DP_RESET_BIT = 3;
	localparam int CTRL_SIGN_EN_BIT = 4;
	localparam int CTRL_SIGN_SRC_BIT = 5;
	localparam int CTRL_MODE_BIT = 6;
	localparam int CTRL_W = 7;
	localparam int STAT_LEVEL_LSB = 16;

	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h08;
	localparam logic [ACC_W-1:0] FREQ_RST = 28'h0000000;
	localparam logic [PH_W-1:0] PHASE_RST = 12'h000;
	localparam logic [DAC_W-1:0] DAC_MID = 10'h200;
	localparam logic [8:0] AMP_MAX = 9'h1FF;
	localparam logic [11:0] HALF_CYCLE = 12'h800;

	typedef struct packed {
		logic mode_tri;
		logic sign_src;
		logic sign_en;
		logic dp_reset;
		logic pin_mode;
		logic psel;
		logic freq_word_select_bit;
	} nco_ctrl_t;
endpackage

// File: design/nco_stream_if.sv
// Stream carrier between the datapath and the sample FIFO
`timescale 1ns/10ps
interface nco_stream_if #(parameter int WIDTH = 10, parameter int DEPTH = 32);
	logic push_valid;
	logic push_ready;
	logic [WIDTH-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [WIDTH-1:0] pop_data;
	logic [$clog2(DEPTH):0] level;
	modport src (output push_valid, output push_data, input push_ready,
		input level);
	modport fifo (input push_valid, input push_data, output push_ready,
		output pop_valid, output pop_data, input pop_ready, output level);
	modport snk (input pop_valid, input pop_data, output pop_ready);
endinterface

// File: design/nco_fifo.sv
// Sample FIFO, flip-flop storage, power-of-two depth
`timescale 1ns/10ps
module nco_fifo import nco_pkg::*; #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32
) (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	nco_stream_if.fifo st
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [PW:0] cnt;
	} nco_fifo_state_t;

	nco_fifo_state_t s_q, s_d;
	logic push, pop;

	assign st.push_ready = (s_q.cnt != FULL);
	assign st.pop_valid = (s_q.cnt != '0);
	assign st.pop_data = s_q.mem[s_q.rd];
	assign st.level = s_q.cnt;

	always_comb begin
		s_d = s_q;
		push = st.push_valid && st.push_ready;
		pop = st.pop_valid && st.pop_ready;
		if (push) begin
			s_d.mem[s_q.wr] = st.push_data;
			s_d.wr = s_q.wr + 1'b1;
		end
		if (pop) begin
			s_d.rd = s_q.rd + 1'b1;
		end
		if (push && !pop) begin
			s_d.cnt = s_q.cnt + 1'b1;
		end else if (pop && !push) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// File: design/nco_top.sv
// Oscillator, phase modulator, sine lookup and register slave
`timescale 1ns/10ps
module nco_top import nco_pkg::*; (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic [ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic freq_word_select_pin_in,
	input wire logic phase_offset_select_pin_in,
	input wire logic dp_reset_pin_in,
	input wire logic comparator_in,
	output logic [DAC_W-1:0] dac_code_out,
	output logic dac_valid_out,
	input wire logic dac_ready_in,
	output logic sign_bit_out
);
	typedef struct packed {
		nco_ctrl_t ctrl;
		logic [ACC_W-1:0] freq_a;
		logic [ACC_W-1:0] freq_b;
		logic [PH_W-1:0] phase_a;
		logic [PH_W-1:0] phase_b;
		logic ack;
		logic [31:0] rdata;
		logic [1:0] fpin_s;
		logic [1:0] ppin_s;
		logic [1:0] rpin_s;
		logic [1:0] comp_s;
		logic [ACC_W-1:0] acc;
		logic [PH_W-1:0] ph;
		logic [DAC_W-1:0] code;
		logic code_vld;
		logic sign;
	} nco_state_t;

	nco_state_t s_q, s_d;
	nco_stream_if #(.WIDTH(DAC_W), .DEPTH(FIFO_DEPTH)) stream ();

	logic adv, freq_word_select_bit, psel, dp_rst, use_sine, req;
	logic [ACC_W-1:0] incr;
	logic [PH_W-1:0] offset;
	logic [10:0] half;
	logic [22:0] prod;
	logic [8:0] amp;
	logic [DAC_W-1:0] code_next;
	logic [31:0] be_mask;
	logic [31:0] wmask;

	nco_fifo #(.WIDTH(DAC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.st(stream.fifo)
	);

	assign stream.push_valid = s_q.code_vld;
	assign stream.push_data = s_q.code;
	assign stream.pop_ready = dac_ready_in;
	assign dac_code_out = stream.pop_data;
	assign dac_valid_out = stream.pop_valid;
	assign avs_readdata_out = s_q.rdata;
	assign sign_bit_out = s_q.sign;
	assign req = avs_read_in || avs_write_in;
	// One wait state per access
	assign avs_waitrequest_out = req && !s_q.ack;

	always_comb begin
		s_d = s_q;
		be_mask = '0;
		for (int i = 0; i < 4; i++) begin
			be_mask[i*8 +: 8] = {8{avs_byteenable_in[i]}};
		end
		wmask = avs_writedata_in & be_mask;

		// Pin synchronisers
		s_d.fpin_s = {s_q.fpin_s[0], freq_word_select_pin_in};
		s_d.ppin_s = {s_q.ppin_s[0], phase_offset_select_pin_in};
		s_d.rpin_s = {s_q.rpin_s[0], dp_reset_pin_in};
		s_d.comp_s = {s_q.comp_s[0], comparator_in};

		// Bus slave
		s_d.ack = req && !s_q.ack;
		if (avs_read_in && !s_q.ack) begin
			case (avs_address_in)
				OFS_CTRL: s_d.rdata = 32'(s_q.ctrl);
				OFS_FREQ_A: s_d.rdata = 32'(s_q.freq_a);
				OFS_FREQ_B: s_d.rdata = 32'(s_q.freq_b);
				OFS_PHASE_A: s_d.rdata = 32'(s_q.phase_a);
				OFS_PHASE_B: s_d.rdata = 32'(s_q.phase_b);
				OFS_STATUS: begin
					s_d.rdata = 32'(s_q.ph);
					s_d.rdata[STAT_LEVEL_LSB +: $clog2(FIFO_DEPTH)+1] =
						stream.level;
				end
				default: s_d.rdata = 32'h00000000;
			endcase
		end
		// Write lands on the edge after the one that ends the wait
		if (avs_write_in && s_q.ack) begin
			case (avs_address_in)
				OFS_CTRL: s_d.ctrl = CTRL_W'((32'(s_q.ctrl) & ~be_mask) | wmask);
				OFS_FREQ_A: s_d.freq_a =
					ACC_W'((32'(s_q.freq_a) & ~be_mask) | wmask);
				OFS_FREQ_B: s_d.freq_b =
					ACC_W'((32'(s_q.freq_b) & ~be_mask) | wmask);
				OFS_PHASE_A: s_d.phase_a =
					PH_W'((32'(s_q.phase_a) & ~be_mask) | wmask);
				OFS_PHASE_B: s_d.phase_b =
					PH_W'((32'(s_q.phase_b) & ~be_mask) | wmask);
				default: ;
			endcase
		end

		// Selections follow pins or control bits every cycle
		freq_word_select_bit = s_q.ctrl.pin_mode ? s_q.fpin_s[1] : s_q.ctrl.freq_word_select_bit;
		psel = s_q.ctrl.pin_mode ? s_q.ppin_s[1] : s_q.ctrl.psel;
		incr = freq_word_select_bit ? s_q.freq_b : s_q.freq_a;
		offset = psel ? s_q.phase_b : s_q.phase_a;
		dp_rst = s_q.ctrl.dp_reset || s_q.rpin_s[1];
		adv = stream.push_ready || !s_q.code_vld;

		// Sine: parabolic half-wave addressed by 12-bit phase
		half = s_q.ph[10:0];
		prod = 23'(half) * 23'(HALF_CYCLE - {1'b0, half});
		amp = (prod[22:11] > 12'(AMP_MAX)) ? AMP_MAX : prod[19:11];
		use_sine = !s_q.ctrl.mode_tri || s_q.ctrl.sign_en;
		if (use_sine) begin
			code_next = s_q.ph[PH_W-1] ? DAC_MID - 10'(amp) :
				DAC_MID + 10'(amp);
		end else begin
			code_next = s_q.ph[PH_W-1] ? ~s_q.ph[10:1] : s_q.ph[10:1];
		end

		if (dp_rst) begin
			s_d.acc = '0;
			s_d.ph = '0;
			s_d.code_vld = 1'b1;
			s_d.code = DAC_MID;
		end else if (adv) begin
			s_d.acc = s_q.acc + incr;
			s_d.ph = s_q.acc[ACC_W-1 -: PH_W] + offset;
			s_d.code = code_next;
			s_d.code_vld = 1'b1;
		end

		// Sign pin source
		if (!s_q.ctrl.sign_en) begin
			s_d.sign = 1'b0;
		end else if (s_q.ctrl.sign_src) begin
			s_d.sign = s_q.comp_s[1];
		end else begin
			s_d.sign = s_q.ph[PH_W-1];
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_q <= '0;
			s_q.ctrl <= CTRL_RST;
			s_q.freq_a <= FREQ_RST;
			s_q.freq_b <= FREQ_RST;
			s_q.phase_a <= PHASE_RST;
			s_q.phase_b <= PHASE_RST;
			s_q.code <= DAC_MID;
		end else begin
			s_q <= s_d;
		end
	end

	// Checks
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rstn_in);

	logic run;
	assign run = !dp_rst && adv;

	property p_acc_step;
		run |=> s_q.acc == ACC_W'($past(s_q.acc) + $past(incr));
	endproperty
	a_acc_step: assert property (p_acc_step)
		else $error("accumulator did not advance by increment");

	property p_incr_sel;
		run && !s_q.ctrl.pin_mode && s_q.ctrl.freq_word_select_bit |=>
			s_q.acc == ACC_W'($past(s_q.acc) + $past(s_q.freq_b));
	endproperty
	a_incr_sel: assert property (p_incr_sel)
		else $error("bit select did not pick frequency word b");

	property p_no_clear_on_switch;
		$changed(freq_word_select_bit) && run |=> s_q.acc == ACC_W'($past(s_q.acc) + $past(incr));
	endproperty
	a_no_clear_on_switch: assert property (p_no_clear_on_switch)
		else $error("accumulator disturbed by frequency switch");

	property p_phase_sum;
		run |=> s_q.ph ==
			PH_W'($past(s_q.acc[ACC_W-1 -: PH_W]) + $past(offset));
	endproperty
	a_phase_sum: assert property (p_phase_sum)
		else $error("phase offset sum wrong");

	property p_dp_reset;
		dp_rst && !avs_write_in |=> s_q.acc == '0 && s_q.ph == '0
			&& $stable(s_q.freq_a) && $stable(s_q.phase_a)
			&& s_q.code == DAC_MID;
	endproperty
	a_dp_reset: assert property (p_dp_reset)
		else $error("datapath reset misbehaved");

	property p_sine_zero;
		run && use_sine && s_q.ph == '0 |=> s_q.code == DAC_MID;
	endproperty
	a_sine_zero: assert property (p_sine_zero)
		else $error("sine at zero phase not midscale");

	property p_comp_path;
		s_q.ctrl.sign_en && s_q.ctrl.sign_src ##1
			s_q.ctrl.sign_en && s_q.ctrl.sign_src |-> sign_bit_out ==
			$past(s_q.comp_s[1]);
	endproperty
	a_comp_path: assert property (p_comp_path)
		else $error("comparator not routed to sign pin");

	property p_msb_path;
		s_q.ctrl.sign_en && !s_q.ctrl.sign_src |=> sign_bit_out ==
			$past(s_q.ph[PH_W-1]);
	endproperty
	a_msb_path: assert property (p_msb_path)
		else $error("oscillator MSB not routed to sign pin");

	property p_sign_off;
		!s_q.ctrl.sign_en |=> !sign_bit_out;
	endproperty
	a_sign_off: assert property (p_sign_off)
		else $error("sign pin active while disabled");

	property p_tri_mode;
		run && !use_sine |=> s_q.code == ($past(s_q.ph[PH_W-1]) ?
			~$past(s_q.ph[10:1]) : $past(s_q.ph[10:1]));
	endproperty
	a_tri_mode: assert property (p_tri_mode)
		else $error("triangle output wrong");

	property p_freq_a_bit;
		run && !s_q.ctrl.pin_mode && !s_q.ctrl.freq_word_select_bit |=>
			s_q.acc == ACC_W'($past(s_q.acc) + $past(s_q.freq_a));
	endproperty
	a_freq_a_bit: assert property (p_freq_a_bit)
		else $error("bit select did not pick frequency word a");

	property p_freq_b_pin;
		run && s_q.ctrl.pin_mode && s_q.fpin_s[1] |=>
			s_q.acc == ACC_W'($past(s_q.acc) + $past(s_q.freq_b));
	endproperty
	a_freq_b_pin: assert property (p_freq_b_pin)
		else $error("pin select did not pick frequency word b");

	property p_freq_a_pin;
		run && s_q.ctrl.pin_mode && !s_q.fpin_s[1] |=>
			s_q.acc == ACC_W'($past(s_q.acc) + $past(s_q.freq_a));
	endproperty
	a_freq_a_pin: assert property (p_freq_a_pin)
		else $error("pin select did not pick frequency word a");

	property p_phase_a_bit;
		run && !s_q.ctrl.pin_mode && !s_q.ctrl.psel |=> s_q.ph ==
			PH_W'($past(s_q.acc[ACC_W-1 -: PH_W]) + $past(s_q.phase_a));
	endproperty
	a_phase_a_bit: assert property (p_phase_a_bit)
		else $error("bit select did not pick phase register a");

	property p_phase_b_bit;
		run && !s_q.ctrl.pin_mode && s_q.ctrl.psel |=> s_q.ph ==
			PH_W'($past(s_q.acc[ACC_W-1 -: PH_W]) + $past(s_q.phase_b));
	endproperty
	a_phase_b_bit: assert property (p_phase_b_bit)
		else $error("bit select did not pick phase register b");

	property p_phase_b_pin;
		run && s_q.ctrl.pin_mode && s_q.ppin_s[1] |=> s_q.ph ==
			PH_W'($past(s_q.acc[ACC_W-1 -: PH_W]) + $past(s_q.phase_b));
	endproperty
	a_phase_b_pin: assert property (p_phase_b_pin)
		else $error("pin select did not pick phase register b");

	property p_sine_peak;
		run && use_sine && s_q.ph == 12'h400 |=> s_q.code == 10'h3FF;
	endproperty
	a_sine_peak: assert property (p_sine_peak)
		else $error("sine at quarter cycle not full scale");

	property p_sine_trough;
		run && use_sine && s_q.ph == 12'hC00 |=> s_q.code == 10'h001;
	endproperty
	a_sine_trough: assert property (p_sine_trough)
		else $error("sine at three quarter cycle not bottom");

	property p_sine_range;
		run && use_sine |=> s_q.code != 10'h000;
	endproperty
	a_sine_range: assert property (p_sine_range)
		else $error("sine code left the converter range");

	property p_sine_sel;
		run && s_q.ctrl.mode_tri && s_q.ctrl.sign_en && s_q.ph == 12'h400
			|=> s_q.code == 10'h3FF;
	endproperty
	a_sine_sel: assert property (p_sine_sel)
		else $error("sine lookup not used with sign output on");

	property p_tri_sel;
		run && s_q.ctrl.mode_tri && !s_q.ctrl.sign_en && s_q.ph == 12'h200
			|=> s_q.code == 10'h100;
	endproperty
	a_tri_sel: assert property (p_tri_sel)
		else $error("sine lookup used in triangle mode");

	property p_comp_low;
		s_q.ctrl.sign_en && s_q.ctrl.sign_src && !s_q.comp_s[1]
			|=> !sign_bit_out;
	endproperty
	a_comp_low: assert property (p_comp_low)
		else $error("sign pin high with comparator low");

	property p_dp_pin;
		s_q.rpin_s[1] |=> s_q.acc == '0 && s_q.ph == '0
			&& s_q.code == DAC_MID;
	endproperty
	a_dp_pin: assert property (p_dp_pin)
		else $error("reset pin did not clear the datapath");

	property p_regs_kept;
		dp_rst && !avs_write_in |=> $stable(s_q.ctrl)
			&& $stable(s_q.freq_b) && $stable(s_q.phase_b);
	endproperty
	a_regs_kept: assert property (p_regs_kept)
		else $error("datapath reset touched a register");

	property p_stall_hold;
		!dp_rst && !adv |=> $stable(s_q.acc) && $stable(s_q.ph);
	endproperty
	a_stall_hold: assert property (p_stall_hold)
		else $error("accumulator moved while output stalled");

	c_freq_switch: cover property (run ##1 $changed(freq_word_select_bit) && run);
	c_acc_wrap: cover property (run && s_q.acc[ACC_W-1] ##1 !s_q.acc[ACC_W-1]);
	c_fifo_full: cover property (!stream.push_ready);
	c_comp_out: cover property (s_q.ctrl.sign_en && s_q.ctrl.sign_src);
	c_tri_out: cover property (run && !use_sine);
endmodule

// File: testbench/nco_dac_model.sv
// Converter sink model taking samples from the oscillator stream
`timescale 1ns/10ps
module nco_dac_model import nco_pkg::*; (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic stall_in,
	input wire logic [DAC_W-1:0] code_in,
	input wire logic valid_in,
	output logic ready_out,
	output logic [DAC_W-1:0] last_code_out
);
	// Stall on command to back up the sample FIFO
	assign ready_out = !stall_in;
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			last_code_out <= 10'h000;
		end else if (valid_in && ready_out) begin
			last_code_out <= code_in;
		end
	end
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the oscillator, modulator and sample path
`timescale 1ns/10ps
module testbench import nco_pkg::*;;
	logic core_clk_in, rstn_in, rd_q, wr_q, fsp, psp, drp, cmp, stall;
	logic wreq, valid, ready, sign;
	logic [ADDR_W-1:0] adr;
	logic [31:0] wdat, rdat, d1, d2, junk;
	logic [3:0] be;
	logic [DAC_W-1:0] code, last;
	int errors, compares, cycles;
	logic [ADDR_W-1:0] ofs [5] = '{OFS_CTRL, OFS_FREQ_A, OFS_FREQ_B,
		OFS_PHASE_B, 5'h18};
	logic [31:0] rv [5] = '{32'h08, 32'h0, 32'h0, 32'h0, 32'h0};
	// Increment, pin and control, phase step over three cycles
	logic [47:0] ft [5] = '{{28'h0010000, 8'h00, 12'h003},
		{28'hFFF0000, 8'h00, 12'hFFD}, {28'h0010000, 8'h01, 12'h006},
		{28'h0010000, 8'h84, 12'h006}, {28'h0010000, 8'h04, 12'h003}};
	// Pin and control, phase, sample code
	logic [31:0] pt [6] = '{{8'h00, 12'h400, 12'h3FF},
		{8'h02, 12'h200, 12'h380}, {8'h84, 12'h200, 12'h380},
		{8'h04, 12'h400, 12'h3FF}, {8'h50, 12'h400, 12'h3FF},
		{8'h42, 12'h200, 12'h100}};
	// Control, comparator level, sign pin
	logic [8:0] sg [5] = '{{7'h10, 1'b0, 1'b1}, {7'h30, 1'b1, 1'b1},
		{7'h30, 1'b0, 1'b0}, {7'h00, 1'b1, 1'b0}, {7'h20, 1'b1, 1'b0}};

	nco_top dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
		.avs_address_in(adr), .avs_read_in(rd_q), .avs_write_in(wr_q),
		.avs_writedata_in(wdat), .avs_byteenable_in(be),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
		.freq_word_select_pin_in(fsp), .phase_offset_select_pin_in(psp),
		.dp_reset_pin_in(drp), .comparator_in(cmp), .dac_code_out(code),
		.dac_valid_out(valid), .dac_ready_in(ready), .sign_bit_out(sign));
	nco_dac_model sink (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
		.stall_in(stall), .code_in(code), .valid_in(valid),
		.ready_out(ready), .last_code_out(last));

	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end

	task automatic tally_and_finish();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge core_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, got);
		compares++;
		if (exp !== got) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] wd, input logic [3:0] b, output logic [31:0] d);
		@(posedge core_clk_in);
		adr <= a;
		wdat <= wd;
		be <= b;
		rd_q <= !w;
		wr_q <= w;
		do @(posedge core_clk_in); while (wreq !== 1'b0);
		d = rdat;
		rd_q <= 1'b0;
		wr_q <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] wd);
		bus(1'b1, a, wd, 4'hF, junk);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		bus(1'b0, a, 32'h0, 4'h0, d1);
	endtask

	task automatic rd2(input logic [ADDR_W-1:0] a);
		rd(a);
		bus(1'b0, a, 32'h0, 4'h0, d2);
	endtask

	initial begin
		{rstn_in, rd_q, wr_q, fsp, psp, drp, cmp, stall} = 8'h00;
		adr = 5'h00;
		wdat = 32'h0;
		be = 4'h0;
		repeat (3) @(posedge core_clk_in);
		rstn_in <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(ofs[i]);
			chk("reset value", rv[i], d1);
		end
		wr(OFS_FREQ_A, 32'h0FFFFFFF);
		bus(1'b1, OFS_FREQ_A, 32'h0, 4'h1, junk);
		rd(OFS_FREQ_A);
		chk("byte lanes", 32'h0FFFFF00, d1);
		wr(OFS_FREQ_A, 32'h0);
		wr(OFS_PHASE_A, 32'h400);
		wr(OFS_PHASE_B, 32'h200);
		for (int i = 0; i < 6; i++) begin
			psp <= pt[i][31];
			wr(OFS_CTRL, {25'h0, pt[i][30:24]});
			repeat (40) @(posedge core_clk_in);
			rd(OFS_STATUS);
			chk("phase", {20'h0, pt[i][23:12]}, {20'h0, d1[11:0]});
			chk("sample", {20'h0, pt[i][11:0]}, {22'h0, last});
		end
		wr(OFS_FREQ_B, 32'h0020000);
		for (int i = 0; i < 5; i++) begin
			fsp <= ft[i][19];
			wr(OFS_FREQ_A, {4'h0, ft[i][47:20]});
			wr(OFS_CTRL, {25'h0, ft[i][18:12]});
			rd2(OFS_STATUS);
			chk("step", {20'h0, ft[i][11:0]}, {20'h0, d2[11:0] - d1[11:0]});
		end
		wr(OFS_CTRL, 32'h0);
		rd(OFS_STATUS);
		wr(OFS_CTRL, 32'h1);
		bus(1'b0, OFS_STATUS, 32'h0, 4'h0, d2);
		d2[11:0] = d2[11:0] - d1[11:0];
		chk("continuity", 32'h1, {31'h0, d2[11:0] >= 6 && d2[11:0] <= 12});
		stall <= 1'b1;
		repeat (50) @(posedge core_clk_in);
		rd2(OFS_STATUS);
		chk("full level", 32'h20, {26'h0, d1[21:16]});
		chk("stalled phase", d1, d2);
		stall <= 1'b0;
		wr(OFS_CTRL, 32'h08);
		wr(OFS_FREQ_A, 32'h0);
		wr(OFS_PHASE_A, 32'h800);
		drp <= 1'b1;
		wr(OFS_CTRL, 32'h0);
		repeat (40) @(posedge core_clk_in);
		rd(OFS_STATUS);
		chk("held phase", 32'h0, {20'h0, d1[11:0]});
		chk("midscale", {22'h0, DAC_MID}, {22'h0, last});
		rd(OFS_PHASE_A);
		chk("kept phase", 32'h800, d1);
		drp <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			cmp <= sg[i][1];
			wr(OFS_CTRL, {25'h0, sg[i][8:2]});
			repeat (8) @(posedge core_clk_in);
			chk("sign", {31'h0, sg[i][0]}, {31'h0, sign});
		end
		tally_and_finish();
	end
endmodule
